// >>> hw/icc_channel.sv
// Purpose: Input capture channel with Wishbone register access
// Assumes: Timer ticks and source pulses are one-cycle enables on SYS_CLK_I
// Notes: Cascade partner bit and idle/sleep states are plain inputs
//
// Our own choices: register access over Wishbone and the register offsets.
`timescale 1ns/100ps
module icc_channel #(
	parameter int FIFO_DEPTH = 4
) (
	// Clock and reset
	input wire logic SYS_CLK_I,
	input wire logic RST_N_I,
	// Wishbone slave
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [3:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	// Capture pin and system state
	input wire logic CAPTURE_PIN_I,
	input wire logic CPU_IDLE_I,
	input wire logic CPU_SLEEP_I,
	input wire logic PARTNER_CASCADE_I,
	// Time bases and sources
	input wire icc_pkg::icc_tick_t TICK_I,
	input wire icc_pkg::icc_src_t SRC_I,
	// Events
	output logic CAPTURE_IRQ_O,
	output logic WAKE_O,
	output logic CASCADE_ACTIVE_O,
	output logic SYNC_OUT_O
);
	import icc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	logic pin_s1_q, pin_s2_q, pin_s3_q;
	logic [15:0] con1_q, con1_d, con2_q, con2_d, tmr_q, tmr_d;
	logic [3:0] pre_q, pre_d;
	logic [1:0] evt_q, evt_d;
	logic irq_q, irq_d, wake_q, wake_d, ack_q, ack_d;
	logic [31:0] rdat_q, rdat_d;
	logic ovf_q, ovf_d;
	logic rise, fall, halted, tick, src_hit, capture, push, pop;
	logic fifo_empty, fifo_full;
	logic [15:0] fifo_data;
	icc_mode_t mode;
	logic wr_acc, rd_acc;

	// Source decode, shared by sync and trigger paths
	function automatic logic src_pick(input logic [4:0] sel, input icc_src_t s);
		logic r;
		r = 1'b0;
		case (sel) inside
			5'h01, 5'h02, 5'h03, 5'h04: r = s.oc[sel[1:0] - 2'h1];
			5'h0a: r = s.ptg;
			[5'h0b:5'h0f]: r = s.tmr[3'(sel - 5'h0b)];
			[5'h10:5'h13]: r = s.ic[sel[1:0]];
			5'h18, 5'h19, 5'h1a: r = s.cmp[2'(sel - 5'h18)];
			5'h1b: r = s.adc;
			5'h1c: r = s.charge_time_unit;
			default: r = 1'b0; // None or reserved
		endcase
		return r;
	endfunction

	function automatic logic [1:0] evt_limit(input logic [1:0] cpi);
		return cpi; // Code n fires on capture n+1
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Pin synchroniser; edges judged only from the second stage on
	always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			pin_s1_q <= 1'b0;
			pin_s2_q <= 1'b0;
			pin_s3_q <= 1'b0;
		end else begin
			pin_s1_q <= CAPTURE_PIN_I;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
		end
	end
	assign rise = pin_s2_q && !pin_s3_q;
	assign fall = !pin_s2_q && pin_s3_q;

	////////////////////////////////////////////////////////////////////////
	// Capture path
	always_comb begin
		mode = icc_mode_t'(con1_q[2:0]);
		halted = CPU_SLEEP_I || (CPU_IDLE_I && con1_q[IDLE_STOP_BIT]);
		case (con1_q[TSEL_LSB +: 3])
			TSEL_PCLK: tick = 1'b1;
			TSEL_T5: tick = TICK_I.t5;
			TSEL_T4: tick = TICK_I.t4;
			TSEL_T2: tick = TICK_I.t2;
			TSEL_T3: tick = TICK_I.t3;
			default: tick = 1'b0; // Reserved codes stop the count
		endcase
		src_hit = src_pick(con2_q[4:0], SRC_I);
		pre_d = pre_q;
		capture = 1'b0;
		wake_d = 1'b0;
		if (!halted) begin
			case (mode)
				MODE_BOTH: capture = rise || fall;
				MODE_RISE: capture = rise;
				MODE_FALL: capture = fall;
				MODE_PRE4, MODE_PRE16: begin
					if (rise) begin
						pre_d = pre_q + 4'h1;
						capture = pre_q == (mode == MODE_PRE4 ? PRESCALE_4 : PRESCALE_16);
						if (capture) begin
							pre_d = 4'h0;
						end
					end
				end
				default: capture = 1'b0; // Off, unused, wake
			endcase
		end
		if (mode == MODE_WAKE && (CPU_SLEEP_I || CPU_IDLE_I)) begin
			wake_d = rise; // Other control bits play no part
		end
		if (mode == MODE_OFF || mode == MODE_UNUSED) begin
			pre_d = 4'h0;
		end
	end

	// Timer: cleared by sync source unless in trigger mode
	always_comb begin
		tmr_d = tmr_q;
		if (mode == MODE_OFF || mode == MODE_UNUSED || mode == MODE_WAKE) begin
			tmr_d = '0;
		end else if (!halted) begin
			if (!con2_q[TRIG_MODE_BIT] && src_hit) begin
				tmr_d = '0;
			end else if (tick && (!con2_q[TRIG_MODE_BIT] || con2_q[TRIG_STAT_BIT])) begin
				tmr_d = tmr_q + 16'h1;
			end
		end
	end

	// Push when room; a full buffer drops the value
	assign push = capture && !fifo_full;

	// Interrupt grouping
	always_comb begin
		evt_d = evt_q;
		irq_d = 1'b0;
		if (mode == MODE_OFF || mode == MODE_UNUSED) begin
			evt_d = 2'h0;
		end else if (capture) begin
			if (mode == MODE_BOTH || evt_q == evt_limit(con1_q[CPI_LSB +: 2])) begin
				irq_d = 1'b1; // Grouping skipped in both-edge mode
				evt_d = 2'h0;
			end else begin
				evt_d = evt_q + 2'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Wishbone slave: one wait state, ack drops after one cycle
	assign wr_acc = WB_CYC_I && WB_STB_I && WB_WE_I && !ack_q;
	assign rd_acc = WB_CYC_I && WB_STB_I && !WB_WE_I && !ack_q;
	assign pop = rd_acc && WB_ADR_I == ADR_BUF; // Read drains one entry

	always_comb begin
		con1_d = con1_q;
		con2_d = con2_q;
		ack_d = WB_CYC_I && WB_STB_I && !ack_q;
		rdat_d = rdat_q;
		ovf_d = ovf_q;
		if (mode == MODE_OFF) begin
			ovf_d = 1'b0; // Hardware clears on turn-off
		end
		if (capture && fifo_full) begin
			ovf_d = 1'b1; // Set wins over clear
		end
		if (src_hit && con2_q[TRIG_MODE_BIT]) begin
			con2_d[TRIG_STAT_BIT] = 1'b1;
		end
		if (wr_acc) begin
			if (WB_ADR_I == ADR_CON1) begin
				if (WB_SEL_I[0]) con1_d[7:0] = WB_DAT_I[7:0];
				if (WB_SEL_I[1]) con1_d[15:8] = WB_DAT_I[15:8];
				con1_d = con1_d & CON1_MASK;
			end
			if (WB_ADR_I == ADR_CON2) begin
				if (WB_SEL_I[0]) begin
					con2_d[7:0] = WB_DAT_I[7:0];
					if (src_hit && con2_q[TRIG_MODE_BIT]) con2_d[TRIG_STAT_BIT] = 1'b1;
				end
				if (WB_SEL_I[1]) con2_d[15:8] = WB_DAT_I[15:8];
				con2_d = con2_d & CON2_MASK;
			end
		end
		if (rd_acc) begin
			case (WB_ADR_I)
				ADR_CON1: rdat_d = {16'h0, con1_q[15:5], ovf_q, !fifo_empty, con1_q[2:0]};
				ADR_CON2: rdat_d = {16'h0, con2_q};
				ADR_BUF: rdat_d = {16'h0, fifo_data};
				ADR_TMR: rdat_d = {16'h0, tmr_q};
				default: rdat_d = 32'h0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			con1_q <= CON1_RESET;
			con2_q <= CON2_RESET;
			tmr_q <= 16'h0;
			pre_q <= 4'h0;
			evt_q <= 2'h0;
			irq_q <= 1'b0;
			wake_q <= 1'b0;
			ack_q <= 1'b0;
			rdat_q <= 32'h0;
			ovf_q <= 1'b0;
		end else begin
			con1_q <= con1_d;
			con2_q <= con2_d;
			tmr_q <= tmr_d;
			pre_q <= pre_d;
			evt_q <= evt_d;
			irq_q <= irq_d;
			wake_q <= wake_d;
			ack_q <= ack_d;
			rdat_q <= rdat_d;
			ovf_q <= ovf_d;
		end
	end

	// Value captured is the timer as it stands this cycle
	icc_fifo #(
		.WIDTH(16),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_i(SYS_CLK_I),
		.rst_n_i(RST_N_I),
		.flush_i(mode == MODE_OFF),
		.push_i(push),
		.data_i(tmr_q),
		.pop_i(pop),
		.data_o(fifo_data),
		.empty_o(fifo_empty),
		.full_o(fifo_full)
	);

	assign WB_DAT_O = rdat_q;
	assign WB_ACK_O = ack_q;
	assign CAPTURE_IRQ_O = irq_q;
	assign WAKE_O = wake_q;
	assign CASCADE_ACTIVE_O = con2_q[CASCADE_BIT] && PARTNER_CASCADE_I;
	assign SYNC_OUT_O = capture;
endmodule

// >>> shared/icc_pkg.sv
// Purpose: Shared constants and types for the input capture channel
// Assumes: Wishbone classic slave, 32-bit data, word-aligned registers
// Notes: Offsets are byte addresses
package icc_pkg;
	localparam logic [3:0] ADR_CON1 = 4'h0;
	localparam logic [3:0] ADR_CON2 = 4'h4;
	localparam logic [3:0] ADR_BUF = 4'h8;
	localparam logic [3:0] ADR_TMR = 4'hc;
	localparam logic [15:0] CON1_RESET = 16'h0000;
	localparam logic [15:0] CON2_RESET = 16'h000d;
	localparam logic [15:0] CON1_MASK = 16'h3c7f;
	localparam logic [15:0] CON2_MASK = 16'h01df;
	localparam int IDLE_STOP_BIT = 13;
	localparam int TSEL_LSB = 10;
	localparam int CPI_LSB = 5;
	localparam int OVF_BIT = 4;
	localparam int BNE_BIT = 3;
	localparam int CASCADE_BIT = 8;
	localparam int TRIG_MODE_BIT = 7;
	localparam int TRIG_STAT_BIT = 6;
	localparam logic [3:0] PRESCALE_4 = 4'h3;
	localparam logic [3:0] PRESCALE_16 = 4'hf;
	localparam logic [2:0] TSEL_T3 = 3'h0;
	localparam logic [2:0] TSEL_T2 = 3'h1;
	localparam logic [2:0] TSEL_T4 = 3'h2;
	localparam logic [2:0] TSEL_T5 = 3'h3;
	localparam logic [2:0] TSEL_PCLK = 3'h7;
	typedef enum logic [2:0] {
		MODE_OFF = 3'h0,
		MODE_BOTH = 3'h1,
		MODE_RISE = 3'h2,
		MODE_FALL = 3'h3,
		MODE_PRE4 = 3'h4,
		MODE_PRE16 = 3'h5,
		MODE_UNUSED = 3'h6,
		MODE_WAKE = 3'h7
	} icc_mode_t;
	// Timer count clocks as one-cycle enables
	typedef struct packed {
		logic t2;
		logic t3;
		logic t4;
		logic t5;
	} icc_tick_t;
	// Sync and trigger source pulses
	typedef struct packed {
		logic [3:0] ic;
		logic [3:0] oc;
		logic [4:0] tmr;
		logic [2:0] cmp;
		logic adc;
		logic charge_time_unit;
		logic ptg;
	} icc_src_t;
	typedef struct packed {
		logic [15:0] con1;
		logic [15:0] con2;
		logic [15:0] buf_data;
		logic [15:0] tmr;
	} icc_regs_t;
endpackage

// >>> hw/icc_fifo.sv
// Purpose: Small capture FIFO for timestamps
// Assumes: Push of a full FIFO is dropped by the caller
// Notes: Depth is a power of two
`timescale 1ns/100ps
module icc_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Control
	input wire logic flush_i,
	input wire logic push_i,
	input wire logic [WIDTH-1:0] data_i,
	input wire logic pop_i,
	// Status and data
	output logic [WIDTH-1:0] data_o,
	output logic empty_o,
	output logic full_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [WIDTH-1:0] mem_d [DEPTH];
	logic [AW-1:0] rd_q, rd_d, wr_q, wr_d;
	logic [AW:0] cnt_q, cnt_d;
	logic do_push, do_pop;
	always_comb begin
		do_pop = pop_i && cnt_q != '0;
		// A pop in the same cycle frees the slot being written
		do_push = push_i && (cnt_q != (AW+1)'(DEPTH) || do_pop);
		mem_d = mem_q;
		rd_d = rd_q;
		wr_d = wr_q;
		cnt_d = cnt_q;
		if (flush_i) begin
			rd_d = '0;
			wr_d = '0;
			cnt_d = '0;
		end else begin
			if (do_push) begin
				mem_d[wr_q] = data_i;
				wr_d = wr_q + 1'b1;
			end
			if (do_pop) begin
				rd_d = rd_q + 1'b1;
			end
			cnt_d = cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
		end
	end
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= '0;
			end
			rd_q <= '0;
			wr_q <= '0;
			cnt_q <= '0;
		end else begin
			mem_q <= mem_d;
			rd_q <= rd_d;
			wr_q <= wr_d;
			cnt_q <= cnt_d;
		end
	end
	assign data_o = mem_q[rd_q];
	assign empty_o = cnt_q == '0;
	assign full_o = cnt_q == (AW+1)'(DEPTH);
endmodule

// >>> testbench/icc_channel_monitor.sv
// Purpose: Port checker for the capture channel
// Assumes: One clock, async active-low reset
// Notes: Bound into every channel instance
`timescale 1ns/100ps
module icc_channel_monitor #(
	parameter int FIFO_DEPTH = 4
) (
	// Clock, reset and bus
	input wire logic SYS_CLK_I,
	input wire logic RST_N_I,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [3:0] WB_ADR_I,
	input wire logic [31:0] WB_DAT_O,
	input wire logic WB_ACK_O,
	// Pin, state and events
	input wire logic CAPTURE_PIN_I,
	input wire logic CPU_IDLE_I,
	input wire logic CPU_SLEEP_I,
	input wire logic PARTNER_CASCADE_I,
	input wire logic CAPTURE_IRQ_O,
	input wire logic WAKE_O,
	input wire logic CASCADE_ACTIVE_O,
	input wire logic SYNC_OUT_O
);
	import icc_pkg::*;
	logic rd_ack;
	assign rd_ack = WB_ACK_O && !WB_WE_I;
	default clocking cb @(posedge SYS_CLK_I);
	endclocking
	default disable iff (!RST_N_I);
	////////////////////////////////////////
	bus_answer_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
		else $error("request not answered");
	ack_single_a: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack longer than one cycle");
	con1_holes_a: assert property (rd_ack && WB_ADR_I == ADR_CON1 |->
		(WB_DAT_O & ~{16'h0000, CON1_MASK}) == 32'h0) else $error("unused bits set");
	unmapped_zero_a: assert property (rd_ack && WB_ADR_I[1:0] != 2'h0 |-> WB_DAT_O == 32'h0)
		else $error("unmapped read not zero");
	cascade_pair_a: assert property (CASCADE_ACTIVE_O |-> PARTNER_CASCADE_I)
		else $error("cascade without partner");
	capture_cause_a: assert property (SYNC_OUT_O |->
		$past(CAPTURE_PIN_I, 2) != $past(CAPTURE_PIN_I, 3)) else $error("capture without edge");
	irq_follow_a: assert property (CAPTURE_IRQ_O |-> $past(SYNC_OUT_O))
		else $error("interrupt without capture");
	wake_context_a: assert property (WAKE_O |-> ($past(CPU_SLEEP_I) || $past(CPU_IDLE_I)) && !SYNC_OUT_O)
		else $error("wake outside low power");
	wake_pulse_a: assert property (WAKE_O |=> !WAKE_O [*2])
		else $error("wake pulse too long");
	sleep_hold_a: assert property (CPU_SLEEP_I && $past(CPU_SLEEP_I) |-> !SYNC_OUT_O)
		else $error("capture during sleep");
	irq_seen_c: cover property (CAPTURE_IRQ_O);
	wake_seen_c: cover property (WAKE_O);
	cascade_seen_c: cover property (CASCADE_ACTIVE_O);
endmodule
bind icc_channel icc_channel_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) icc_channel_monitor_i (
	.SYS_CLK_I(SYS_CLK_I),
	.RST_N_I(RST_N_I),
	.WB_CYC_I(WB_CYC_I),
	.WB_STB_I(WB_STB_I),
	.WB_WE_I(WB_WE_I),
	.WB_ADR_I(WB_ADR_I),
	.WB_DAT_O(WB_DAT_O),
	.WB_ACK_O(WB_ACK_O),
	.CAPTURE_PIN_I(CAPTURE_PIN_I),
	.CPU_IDLE_I(CPU_IDLE_I),
	.CPU_SLEEP_I(CPU_SLEEP_I),
	.PARTNER_CASCADE_I(PARTNER_CASCADE_I),
	.CAPTURE_IRQ_O(CAPTURE_IRQ_O),
	.WAKE_O(WAKE_O),
	.CASCADE_ACTIVE_O(CASCADE_ACTIVE_O),
	.SYNC_OUT_O(SYNC_OUT_O)
);

// >>> testbench/icc_far_end.sv
// Purpose: Far side of the channel: pin, timer ticks, sources
// Assumes: Bench requests pin level and source pulses
// Notes: Ticks divide the clock by 2, 3, 4 and 5
`timescale 1ns/100ps
module icc_far_end (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Bench requests
	input wire logic pin_lvl_i,
	input wire icc_pkg::icc_src_t src_req_i,
	// Toward the channel
	output logic pin_o,
	output icc_pkg::icc_tick_t tick_o,
	output icc_pkg::icc_src_t src_o
);
	import icc_pkg::*;
	logic [5:0] div_q, div_d;
	////////////////////////////////////////
	always_comb begin
		div_d = (div_q == 6'h3b) ? 6'h00 : div_q + 6'h01;
	end
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			div_q <= 6'h00;
		end else begin
			div_q <= div_d;
		end
	end
	// Period 60 suits every divider, so a 60-cycle span has fixed tick counts
	assign tick_o = {div_q % 2 == 0, div_q % 3 == 0, div_q % 4 == 0, div_q % 5 == 0};
	assign pin_o = pin_lvl_i;
	// Pulses come only from other units, never this channel
	assign src_o = src_req_i;
endmodule

// >>> testbench/tb.sv
// Purpose: Self-checking bench for the capture channel
// Assumes: Bus answer comes one cycle after the request
// Notes: Random gaps and interrupt counts from seed 13
`timescale 1ns/100ps
module tb;
	import icc_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, req = 1'b0, we = 1'b0, pin_lvl = 1'b0, ack, pin;
	logic idle = 1'b0, sleep = 1'b0, pcas = 1'b0, irq, wake, cas, sync;
	logic [3:0] adr = 4'h0;
	logic [31:0] wdat = 32'h0, rdat;
	icc_tick_t tick;
	icc_src_t src, src_req = '0;
	int err_total = 0, cmp_count = 0, n_sync = 0, n_irq = 0, n_wake = 0;
	logic [2:0] mt [10] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h2, 3'h2};
	int ct [10] = '{0, 32, 16, 16, 4, 1, 0, 0, 0, 16};
	logic [2:0] ts [5] = '{TSEL_T3, TSEL_T2, TSEL_T4, TSEL_T5, TSEL_PCLK};
	int tp [5] = '{3, 2, 4, 5, 1};
	always #50 clk = ~clk;
	always @(posedge clk) begin
		n_sync += sync;
		n_irq += irq;
		n_wake += wake;
	end
	icc_far_end icc_far_end_i (.clk_i(clk), .rst_n_i(rst_n), .pin_lvl_i(pin_lvl),
		.src_req_i(src_req), .pin_o(pin), .tick_o(tick), .src_o(src));
	icc_channel #(.FIFO_DEPTH(4)) icc_channel_i (.SYS_CLK_I(clk), .RST_N_I(rst_n),
		.WB_CYC_I(req), .WB_STB_I(req), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'h3),
		.WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .CAPTURE_PIN_I(pin),
		.CPU_IDLE_I(idle), .CPU_SLEEP_I(sleep), .PARTNER_CASCADE_I(pcas), .TICK_I(tick),
		.SRC_I(src), .CAPTURE_IRQ_O(irq), .WAKE_O(wake), .CASCADE_ACTIVE_O(cas),
		.SYNC_OUT_O(sync));
	////////////////////////////////////////
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wb(input logic w, input logic [3:0] a, input logic [15:0] d,
		output logic [31:0] q);
		@(posedge clk);
		req <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {16'h0000, d};
		// Only the watchdog ends a wait that never sees ack
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		q = rdat;
		req <= 1'b0;
	endtask
	task automatic edge_to(input logic lv, input logic pop);
		logic [31:0] d;
		@(posedge clk);
		pin_lvl <= lv;
		repeat ($urandom % 4 + 4) @(posedge clk);
		if (pop) wb(1'b0, ADR_BUF, 16'h0, d);
	endtask
	function automatic icc_src_t src_of(input logic [4:0] c);
		icc_src_t s;
		s = '0;
		if (c inside {[5'h10:5'h13]}) s.ic[c[1:0]] = 1'b1;
		if (c inside {[5'h01:5'h04]}) s.oc[c[1:0] - 2'h1] = 1'b1;
		if (c inside {[5'h0b:5'h0f]}) s.tmr[c - 5'h0b] = 1'b1;
		if (c inside {[5'h18:5'h1a]}) s.cmp[c - 5'h18] = 1'b1;
		s.adc = (c == 5'h1b);
		s.charge_time_unit = (c == 5'h1c);
		s.ptg = (c == 5'h0a);
		return s;
	endfunction
	initial begin
		// Whole run needs well under 20000 cycles
		#2000000;
		err_total++;
		give_verdict();
	end
	initial begin
		logic [31:0] q, t0, cpi;
		int s0, i0, w0;
		icc_src_t s;
		void'($urandom(13));
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		wb(1'b0, ADR_CON1, 16'h0, q);
		check("con1 reset", q, 32'h0);
		wb(1'b0, ADR_CON2, 16'h0, q);
		check("con2 reset", q, 32'hd);
		wb(1'b0, 4'h2, 16'h0, q);
		check("unmapped", q, 32'h0);
		wb(1'b1, ADR_CON1, 16'hffff, q);
		wb(1'b0, ADR_CON1, 16'h0, q);
		check("con1 bits", q, 32'h3c67);
		foreach (ts[i]) begin
			wb(1'b1, ADR_CON1, {3'h0, ts[i], 10'h002}, q);
			wb(1'b0, ADR_TMR, 16'h0, t0);
			repeat (57) @(posedge clk);
			wb(1'b0, ADR_TMR, 16'h0, q);
			check("timer ticks", q - t0, 60 / tp[i]);
		end
		// Trigger mode only, so comparator and converter stay trigger sources
		for (int c = 0; c < 32; c++) begin
			s = src_of(c[4:0]);
			if (s == '0 && c != 0 && c != 31) continue;
			wb(1'b1, ADR_CON2, {8'h00, 3'h4, c[4:0]}, q);
			@(posedge clk);
			src_req <= (s == '0) ? '1 : s;
			@(posedge clk);
			src_req <= '0;
			wb(1'b0, ADR_CON2, 16'h0, q);
			check("trigger status", 32'(q[TRIG_STAT_BIT]), 32'(s != '0));
		end
		wb(1'b1, ADR_CON2, 16'h00c0, q);
		wb(1'b0, ADR_CON2, 16'h0, q);
		check("status set", q, 32'hc0);
		// Sync mode: a source pulse restarts the count
		wb(1'b1, ADR_CON2, 16'h000b, q);
		@(posedge clk);
		src_req <= src_of(5'h0b);
		@(posedge clk);
		src_req <= '0;
		wb(1'b0, ADR_TMR, 16'h0, q);
		check("sync clear", q, 32'h1);
		// Trigger mode with status clear holds the count
		wb(1'b1, ADR_CON2, 16'h0080, q);
		wb(1'b0, ADR_TMR, 16'h0, t0);
		wb(1'b0, ADR_TMR, 16'h0, q);
		check("trigger hold", q, t0);
		for (int k = 0; k < 4; k++) begin
			pcas <= k[1];
			wb(1'b1, ADR_CON2, {7'h00, k[0], 8'h00}, q);
			@(negedge clk);
			check("cascade", 32'(cas), 32'(k == 3));
		end
		pcas <= 1'b0;
		for (int e = 0; e < 10; e++) begin
			cpi = $urandom % 4;
			wb(1'b1, ADR_CON1, 16'h0, q);
			idle <= e > 7;
			sleep <= e == 7;
			wb(1'b1, ADR_CON1, {2'h0, e == 8, 3'h7, 3'h0, cpi[1:0], 2'h0, mt[e]}, q);
			s0 = n_sync;
			i0 = n_irq;
			w0 = n_wake;
			repeat (16) begin
				edge_to(1'b1, 1'b1);
				edge_to(1'b0, 1'b1);
			end
			check("captures", n_sync - s0, ct[e]);
			check("irqs", n_irq - i0, mt[e] == 3'h1 ? ct[e] : ct[e] / (cpi + 1));
			check("wakes", n_wake - w0, 32'(e == 7) << 4);
		end
		idle <= 1'b0;
		sleep <= 1'b0;
		wb(1'b1, ADR_CON1, 16'h1c02, q);
		repeat (5) begin
			edge_to(1'b1, 1'b0);
			edge_to(1'b0, 1'b0);
		end
		wb(1'b0, ADR_CON1, 16'h0, q);
		check("full status", q, 32'h1c1a);
		t0 = 32'h0;
		repeat (4) begin
			wb(1'b0, ADR_BUF, 16'h0, q);
			check("fifo order", 32'(q > t0), 32'h1);
			t0 = q;
		end
		wb(1'b0, ADR_CON1, 16'h0, q);
		check("drained", q, 32'h1c12);
		wb(1'b1, ADR_CON1, 16'h0, q);
		wb(1'b0, ADR_CON1, 16'h0, q);
		check("off status", q, 32'h0);
		give_verdict();
	end
endmodule
